// file: rsbs_lpo_div.sv
/*
  Divider producing a one-cycle enable at the 1 kHz low-power rate.
  Assumes the 50 MHz system clock.
*/
`timescale 1ns/1ps
module rsbs_lpo_div (
  input wire logic clock_i,
  input wire logic rst_n_i,
  output logic tick_o
);
  localparam int unsigned CNT_W_L = 16;
  localparam logic [CNT_W_L-1:0] LAST = CNT_W_L'(rsbs_pkg::LPO_DIV_CYC - 1);
  logic [CNT_W_L-1:0] cnt_q;
  logic [CNT_W_L-1:0] cnt_d;
  logic tick_d;

  // --------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------
  always_comb begin
    tick_d = (cnt_q == LAST);
    cnt_d = tick_d ? '0 : cnt_q + 16'h0001;
  end

  // Registers only
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_o <= tick_d;
    end
  end
endmodule

// file: rsbs_pin_filter.sv
/*
  Glitch filter for the reset pin. A new level is accepted only once it has
  held for the programmed number of bus or low-power clock cycles.
  Assumes the pin is already synchronous to the clock.
*/
`timescale 1ns/1ps
module rsbs_pin_filter (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic flt_rst_i,
  input wire logic lpo_tick_i,
  input wire rsbs_pkg::rsbs_filter_cfg_t cfg_i,
  input wire logic pin_i,
  output logic pin_o
);
  logic [rsbs_pkg::FLT_CFG_W-1:0] cnt_q;
  logic [rsbs_pkg::FLT_CFG_W-1:0] cnt_d;
  logic [rsbs_pkg::FLT_CFG_W-1:0] limit;
  logic step;
  logic out_d;

  // --------------------------------------------------------------
  // Stability count
  // --------------------------------------------------------------
  // Low-power width is clipped to 7 bits so 1..128 applies there
  always_comb begin
    limit = cfg_i.use_lpo ? {5'h00, cfg_i.width_m1[rsbs_pkg::FLT_LPO_W-1:0]} : cfg_i.width_m1;
    step = cfg_i.use_lpo ? lpo_tick_i : 1'b1;
    out_d = pin_o;
    cnt_d = cnt_q;
    if (pin_i == pin_o) begin
      cnt_d = '0;
    end else if (step) begin
      if (cnt_q >= limit) begin
        out_d = pin_i; // RQ6
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + 12'h001;
      end
    end
  end

  // Output idles high: pin pulled up
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      pin_o <= 1'b1;
    end else if (flt_rst_i) begin
      cnt_q <= '0;
      pin_o <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      pin_o <= out_d;
    end
  end
endmodule

// file: rsbs_pin_model.sv
/*
  Far side model: reset pin with pull-up and slow rise, debug port bits.
  Assumes the bench commands external hold, rise time and debug requests.
*/
`timescale 1ns/1ps
module rsbs_pin_model (
  input wire logic clock_i,
  input wire logic drv_i,
  input wire logic drv_oe_i,
  input wire logic hold_low_i,
  input wire logic [7:0] rise_cyc_i,
  input wire logic dbg_sys_cmd_i,
  input wire logic dbg_hold_cmd_i,
  output logic pin_level_o,
  output logic dbg_sys_o,
  output logic dbg_hold_o
);
  // ----------------------------------------------------------------
  // Pin wire
  // ----------------------------------------------------------------
  logic [7:0] rise_q = 8'h00;
  logic low_now;

  // Any driver low wins; the pull-up needs rise_cyc_i cycles after release
  assign low_now = (drv_oe_i && !drv_i) || hold_low_i;
  assign pin_level_o = !(low_now || rise_q != 8'h00);

  always_ff @(posedge clock_i) begin
    if (low_now) begin
      rise_q <= rise_cyc_i;
    end else if (rise_q != 8'h00) begin
      rise_q <= rise_q - 8'h01;
    end
  end

  // Debug port bits held as levels until the host clears them
  always_ff @(posedge clock_i) begin
    dbg_sys_o <= dbg_sys_cmd_i;
    dbg_hold_o <= dbg_hold_cmd_i;
  end
endmodule

// file: rsbs_pkg.sv
/*
  Package for the reset source and boot sequencer: timing counts, status bit
  positions, clock-mode encodings and the struct types shared by the files.
  Assumes a single 50 MHz system clock.
*/
package rsbs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned PIN_DRIVE_NS = 4200;
  localparam int unsigned PIN_DRIVE_CYC = (PIN_DRIVE_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned FLASH_INIT_NS = 16000;
  localparam int unsigned FLASH_INIT_CYC = (FLASH_INIT_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned LPO_HZ = 1000;
  localparam int unsigned LPO_DIV_CYC = CLK_HZ / LPO_HZ;
  localparam int unsigned STOP_ACK_LPO_CYC = 1025;
  localparam int unsigned CNT_W = 16;

  // ----------------------------------------------------------------
  // Pin filter configuration
  // ----------------------------------------------------------------
  localparam int unsigned FLT_BUS_W = 12;  // 1..4096 bus cycles, width-1 coded
  localparam int unsigned FLT_LPO_W = 7;   // 1..128 low-power cycles
  localparam int unsigned FLT_CFG_W = 12;

  // ----------------------------------------------------------------
  // Reset source status bit positions
  // ----------------------------------------------------------------
  localparam int unsigned SRC_W = 9;
  localparam int unsigned SRC_POR = 0;
  localparam int unsigned SRC_PIN = 1;
  localparam int unsigned SRC_LVD = 2;
  localparam int unsigned SRC_WDG = 3;
  localparam int unsigned SRC_LOC = 4;
  localparam int unsigned SRC_SACK = 5;
  localparam int unsigned SRC_SW = 6;
  localparam int unsigned SRC_LOCKUP = 7;
  localparam int unsigned SRC_DBG = 8;
  localparam logic [SRC_W-1:0] SRC_RESET = 9'h000;

  // ----------------------------------------------------------------
  // Core boot values
  // ----------------------------------------------------------------
  localparam logic [31:0] VEC_SP_OFFSET = 32'h0000_0000;
  localparam logic [31:0] VEC_PC_OFFSET = 32'h0000_0004;
  localparam logic [31:0] LINK_RESET = 32'hFFFF_FFFF;

  // ----------------------------------------------------------------
  // Clock generator modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CLKMODE_INT_ENGAGED = 3'h0,
    CLKMODE_EXT_BYPASS = 3'h1,
    CLKMODE_EXT_BYPASS_LP = 3'h2,
    CLKMODE_EXT_ENGAGED = 3'h3,
    CLKMODE_INT_BYPASS_LP = 3'h4,
    CLKMODE_INT_BYPASS = 3'h5
  } rsbs_clkmode_t;

  // Raw reset events from around the chip
  typedef struct packed {
    logic por;
    logic lvd_trip;
    logic watchdog_reset_flag_timeout;
    logic loss_of_clock;
    logic stop_req;
    logic stop_ack_all;
    logic soft_reset_request;
    logic lockup;
    logic dbg_sys_reset;
    logic dbg_core_hold;
  } rsbs_events_t;

  // Reset domains, active high
  typedef struct packed {
    logic por_only;
    logic chip_por;
    logic early_chip;
    logic chip;
    logic core;
  } rsbs_domains_t;

  // Pin filter setup
  typedef struct packed {
    logic use_lpo;
    logic [FLT_CFG_W-1:0] width_m1;
  } rsbs_filter_cfg_t;

endpackage

// file: rsbs_top.sv
/*
  Reset source collector and boot sequencer. Gathers every reset source,
  keeps sticky source flags, drives the four reset domains plus a core hold,
  sequences pin drive, pin release wait, flash init and core start.
  Assumes inputs synchronous to the 50 MHz clock; rst_n_i is the power-on
  reset from the analog supply monitor.
*/
// Functional notes
// RQ1: One status flag per system reset source.
// RQ2: Power-on sets power-on and low-voltage flags.
// RQ3: Core loads stack 0, PC 4, link ones.
// RQ4: Pin is reset input until enable cleared.
// RQ5: Pin assertion wakes and resets the device.
// RQ6: Pin filter rejects pulses below programmed width.
// RQ7: Low-voltage detect gated by enable, level select.
// RQ8: Stop disables detector unless stop-enable or debug.
// RQ9: Watchdog timeout resets and sets its flag.
// RQ10: Clock monitor armed only in external modes.
// RQ11: Software starts loop before arming monitor.
// RQ12: Stop unacknowledged 1025 slow cycles forces reset.
// RQ13: Software reset spares the debug module.
// RQ14: Core lockup resets and sets its flag.
// RQ15: Debug holds system reset; core-hold keeps core.
// RQ16: Power-only domain only on power-on, triggers all.
// RQ17: Chip power domain on power-on and low-voltage.
// RQ18: Early reset on all sources, released before flash.
// RQ19: Full chip reset released after pin release.
// RQ20: Drive pin low 4.2 us, enable clock generator.
// RQ21: Wait for pin high, then release system.
// RQ22: Core starts after 16 us flash init.
`timescale 1ns/1ps
module rsbs_top (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire rsbs_pkg::rsbs_events_t events_i,
  input wire logic reset_pin_enable_i,
  input wire logic shared_port_pin_i,
  input wire rsbs_pkg::rsbs_filter_cfg_t pin_filter_cfg_i,
  input wire logic lowvolt_enable_i,
  input wire logic lowvolt_level_select_i,
  input wire logic lowvolt_stop_enable_i,
  input wire logic in_stop_i,
  input wire logic debug_mode_i,
  input wire logic clock_monitor_enable_i,
  input wire rsbs_pkg::rsbs_clkmode_t clock_mode_i,
  input wire logic status_clear_i,
  output logic shared_port_pin_o,
  output logic shared_port_pin_oe_o,
  output rsbs_pkg::rsbs_domains_t domains_o,
  output logic [rsbs_pkg::SRC_W-1:0] reset_source_status_reg_o,
  output logic clock_generator_enable_o,
  output logic core_clock_enable_o,
  output logic lowvolt_active_o,
  output logic lowvolt_level_high_o,
  output logic clock_monitor_active_o,
  output logic core_fetch_start_o,
  output logic [31:0] core_sp_addr_o,
  output logic [31:0] core_pc_addr_o,
  output logic [31:0] core_link_o
);

  // --------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POR,
    ST_DRIVE,
    ST_WAIT_PIN,
    ST_FLASH,
    ST_RUN
  } rsbs_state_t;

  rsbs_state_t state_q;
  rsbs_state_t state_d;
  logic [rsbs_pkg::CNT_W-1:0] cnt_q;
  logic [rsbs_pkg::CNT_W-1:0] cnt_d;
  logic [10:0] sack_q;
  logic [10:0] sack_d;
  logic [rsbs_pkg::SRC_W-1:0] status_d;
  logic [rsbs_pkg::SRC_W-1:0] src_now;
  logic lpo_tick;
  logic pin_filt;
  logic pin_low;
  logic lvd_on;
  logic mon_on;
  logic sack_err;
  logic any_sys;
  logic por_boot_q;
  logic por_boot_d;
  rsbs_pkg::rsbs_domains_t dom_d;
  logic drive_d;
  logic clkgen_d;
  logic coreclk_d;
  logic fetch_d;

  localparam logic [rsbs_pkg::CNT_W-1:0] DRIVE_LAST =
    rsbs_pkg::CNT_W'(rsbs_pkg::PIN_DRIVE_CYC - 1);
  localparam logic [rsbs_pkg::CNT_W-1:0] FLASH_LAST =
    rsbs_pkg::CNT_W'(rsbs_pkg::FLASH_INIT_CYC - 1);
  localparam logic [10:0] SACK_LIMIT = 11'(rsbs_pkg::STOP_ACK_LPO_CYC);

  // --------------------------------------------------------------
  // Slow clock and pin filter
  // --------------------------------------------------------------
  rsbs_lpo_div u_lpo (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .tick_o(lpo_tick)
  );

  // Filter registers cleared by the chip power-on domain
  rsbs_pin_filter u_flt (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .flt_rst_i(domains_o.chip_por), // RQ17
    .lpo_tick_i(lpo_tick),
    .cfg_i(pin_filter_cfg_i),
    .pin_i(shared_port_pin_i),
    .pin_o(pin_filt)
  );

  // --------------------------------------------------------------
  // Source qualification
  // --------------------------------------------------------------
  // Pin counts as reset only while it is still the reset function
  always_comb begin
    pin_low = reset_pin_enable_i && !pin_filt; // RQ4
    lvd_on = lowvolt_enable_i && (!in_stop_i || lowvolt_stop_enable_i
      || debug_mode_i); // RQ7 RQ8
    mon_on = clock_monitor_enable_i && ((clock_mode_i == rsbs_pkg::CLKMODE_EXT_BYPASS)
      || (clock_mode_i == rsbs_pkg::CLKMODE_EXT_ENGAGED)); // RQ10
    sack_err = (sack_q >= SACK_LIMIT); // RQ12
    src_now = '0;
    src_now[rsbs_pkg::SRC_PIN] = pin_low && (state_q == rsbs_pkg_run_state()); // RQ5
    src_now[rsbs_pkg::SRC_LVD] = lvd_on && events_i.lvd_trip;
    src_now[rsbs_pkg::SRC_WDG] = events_i.watchdog_reset_flag_timeout; // RQ9
    src_now[rsbs_pkg::SRC_LOC] = mon_on && events_i.loss_of_clock; // RQ10
    src_now[rsbs_pkg::SRC_SACK] = sack_err; // RQ12
    src_now[rsbs_pkg::SRC_SW] = events_i.soft_reset_request; // RQ13
    src_now[rsbs_pkg::SRC_LOCKUP] = events_i.lockup; // RQ14
    src_now[rsbs_pkg::SRC_DBG] = events_i.dbg_sys_reset; // RQ15
    any_sys = |src_now;
  end

  function automatic rsbs_state_t rsbs_pkg_run_state();
    return ST_RUN;
  endfunction

  // --------------------------------------------------------------
  // Stop acknowledge watchdog
  // --------------------------------------------------------------
  // Counts slow ticks while stop is pending and not fully acknowledged
  always_comb begin
    sack_d = sack_q;
    if (!events_i.stop_req || events_i.stop_ack_all || state_q != ST_RUN) begin
      sack_d = '0;
    end else if (lpo_tick && !sack_err) begin
      sack_d = sack_q + 11'h001; // RQ12
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sack_q <= '0;
    end else begin
      sack_q <= sack_d;
    end
  end

  // --------------------------------------------------------------
  // Reset source status
  // --------------------------------------------------------------
  // New reset replaces old flags so they name the latest cause; set wins
  always_comb begin
    status_d = reset_source_status_reg_o;
    if (status_clear_i) begin
      status_d = '0;
    end
    if (por_boot_q) begin
      status_d = '0;
      status_d[rsbs_pkg::SRC_POR] = 1'b1; // RQ2
      status_d[rsbs_pkg::SRC_LVD] = 1'b1; // RQ2
    end else if (any_sys && state_q == ST_RUN) begin
      status_d = src_now; // RQ1
    end else if (any_sys) begin
      status_d = status_d | src_now; // RQ1
    end
  end

  // --------------------------------------------------------------
  // Boot sequencer
  // --------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    por_boot_d = 1'b0;
    unique case (state_q)
      ST_POR: begin
        state_d = ST_DRIVE;
        cnt_d = '0;
      end
      ST_DRIVE: begin
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q >= DRIVE_LAST) begin
          state_d = ST_WAIT_PIN; // RQ20
          cnt_d = '0;
        end
      end
      ST_WAIT_PIN: begin
        // Raw pin read: the filter is cleared only by the chip power-on domain, which is off here
        if (shared_port_pin_i && !any_sys) begin
          state_d = ST_FLASH; // RQ21 RQ15
        end
      end
      ST_FLASH: begin
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q >= FLASH_LAST) begin
          state_d = ST_RUN; // RQ22
        end
      end
      ST_RUN: begin
        cnt_d = '0;
      end
    endcase
    // Held sources park in WAIT_PIN; DRIVE is not restarted so the pin pulse keeps its width
    if (any_sys && (state_q == ST_FLASH || state_q == ST_RUN)) begin
      state_d = ST_DRIVE; // RQ5
      cnt_d = '0;
    end
  end

  // --------------------------------------------------------------
  // Domain and output decode
  // --------------------------------------------------------------
  always_comb begin
    dom_d.por_only = (state_q == ST_POR); // RQ16
    dom_d.chip_por = (state_q == ST_POR) || src_now[rsbs_pkg::SRC_LVD]
      || por_boot_q; // RQ17
    dom_d.early_chip = (state_d == ST_DRIVE) || (state_d == ST_WAIT_PIN)
      || (state_d == ST_POR); // RQ18
    dom_d.chip = dom_d.early_chip; // RQ19
    dom_d.core = (state_d != ST_RUN) || events_i.dbg_core_hold; // RQ22 RQ15
    drive_d = (state_d == ST_DRIVE); // RQ20
    clkgen_d = (state_d != ST_POR); // RQ20
    coreclk_d = (state_d == ST_FLASH) || (state_d == ST_RUN); // RQ21
    fetch_d = domains_o.core && !dom_d.core; // RQ22
  end

  // Power-on flag stays one cycle past reset so the flags get loaded
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_POR;
      cnt_q <= '0;
      por_boot_q <= 1'b1;
      reset_source_status_reg_o <= rsbs_pkg::SRC_RESET;
      domains_o <= '1; // RQ16
      shared_port_pin_o <= 1'b0;
      shared_port_pin_oe_o <= 1'b0;
      clock_generator_enable_o <= 1'b0;
      core_clock_enable_o <= 1'b0;
      lowvolt_active_o <= 1'b0;
      lowvolt_level_high_o <= 1'b0;
      clock_monitor_active_o <= 1'b0;
      core_fetch_start_o <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      por_boot_q <= por_boot_d;
      reset_source_status_reg_o <= status_d;
      domains_o <= dom_d;
      shared_port_pin_o <= 1'b0;
      shared_port_pin_oe_o <= drive_d; // RQ20
      clock_generator_enable_o <= clkgen_d;
      core_clock_enable_o <= coreclk_d;
      lowvolt_active_o <= lvd_on; // RQ7
      lowvolt_level_high_o <= lowvolt_level_select_i; // RQ7
      clock_monitor_active_o <= mon_on;
      core_fetch_start_o <= fetch_d; // RQ3
    end
  end

  // Boot vector addresses and link value are fixed
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_sp_addr_o <= rsbs_pkg::VEC_SP_OFFSET;
      core_pc_addr_o <= rsbs_pkg::VEC_PC_OFFSET;
      core_link_o <= rsbs_pkg::LINK_RESET;
    end else begin
      core_sp_addr_o <= rsbs_pkg::VEC_SP_OFFSET; // RQ3
      core_pc_addr_o <= rsbs_pkg::VEC_PC_OFFSET; // RQ3
      core_link_o <= rsbs_pkg::LINK_RESET; // RQ3
    end
  end
endmodule

// file: rsbs_top_asserts.sv
/*
  Checker for rsbs_top: pin drive, domain release order and source gating.
  Assumes a bind to rsbs_top and a view of its ports only.
*/
`timescale 1ns/1ps
module rsbs_top_asserts (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire rsbs_pkg::rsbs_events_t events_i,
  input wire logic shared_port_pin_i,
  input wire logic lowvolt_enable_i,
  input wire logic lowvolt_stop_enable_i,
  input wire logic in_stop_i,
  input wire logic debug_mode_i,
  input wire logic clock_monitor_enable_i,
  input wire rsbs_pkg::rsbs_clkmode_t clock_mode_i,
  input wire logic shared_port_pin_o,
  input wire logic shared_port_pin_oe_o,
  input wire rsbs_pkg::rsbs_domains_t domains_o,
  input wire logic [rsbs_pkg::SRC_W-1:0] reset_source_status_reg_o,
  input wire logic lowvolt_active_o,
  input wire logic clock_monitor_active_o,
  input wire logic core_fetch_start_o,
  input wire logic [31:0] core_sp_addr_o,
  input wire logic [31:0] core_pc_addr_o,
  input wire logic [31:0] core_link_o
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic [15:0] drv_q, drv_d, fl_q, fl_d;

  // Run lengths of pin drive and of the flash wait after chip release
  always_comb begin
    drv_d = shared_port_pin_oe_o ? drv_q + 16'h0001 : 16'h0000;
    fl_d = domains_o.chip ? 16'h0000 : (domains_o.core ? fl_q + 16'h0001 : fl_q);
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drv_q <= 16'h0000;
      fl_q <= 16'h0000;
    end else begin
      drv_q <= drv_d;
      fl_q <= fl_d;
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_pin_drive_low: assert property (shared_port_pin_oe_o |-> !shared_port_pin_o)
    else $error("pin driven high");
  a_drive_width: assert property ($fell(shared_port_pin_oe_o) |-> drv_q == 16'h00D2)
    else $error("pin drive width wrong");
  a_chip_after_pin: assert property ($fell(domains_o.chip) |-> $past(shared_port_pin_i))
    else $error("chip released while pin low");
  a_early_before_core: assert property (domains_o.early_chip |-> domains_o.core)
    else $error("core released before early reset");
  a_flash_wait: assert property ($fell(domains_o.core) |-> fl_q >= 16'h0320)
    else $error("core released before flash init");
  a_fetch_pulse: assert property (core_fetch_start_o |-> !domains_o.core ##1 !core_fetch_start_o)
    else $error("fetch pulse wrong");
  a_boot_vectors: assert property (core_fetch_start_o |-> core_sp_addr_o == 32'h0000_0000 &&
    core_pc_addr_o == 32'h0000_0004 && core_link_o == 32'hFFFF_FFFF)
    else $error("boot vectors wrong");
  a_clkmon_gate: assert property (clock_monitor_active_o |-> $past(clock_monitor_enable_i) &&
    $past(clock_mode_i) inside {rsbs_pkg::CLKMODE_EXT_BYPASS, rsbs_pkg::CLKMODE_EXT_ENGAGED})
    else $error("clock monitor active out of mode");
  a_lowvolt_gate: assert property (lowvolt_active_o |-> $past(lowvolt_enable_i) &&
    (!$past(in_stop_i) || $past(lowvolt_stop_enable_i) || $past(debug_mode_i)))
    else $error("low-voltage detect active when off");
  a_watchdog_reset_flag_reset: assert property (events_i.watchdog_reset_flag_timeout && !domains_o.chip |=>
    domains_o.chip && domains_o.early_chip && reset_source_status_reg_o[3])
    else $error("watchdog reset missing");
  a_lockup_reset: assert property (events_i.lockup && !domains_o.chip |=>
    domains_o.chip && reset_source_status_reg_o[7])
    else $error("lockup reset missing");
  a_debug_hold: assert property (events_i.dbg_sys_reset |=> domains_o.chip && domains_o.core)
    else $error("debug reset not held");
  a_power_flags: assert property ($rose(rst_n_i) |=>
    reset_source_status_reg_o[0] && reset_source_status_reg_o[2])
    else $error("power-on flags missing");
  a_por_scope: assert property (domains_o.por_only |-> domains_o.chip_por && domains_o.chip)
    else $error("power-on domain scope wrong");
endmodule

bind rsbs_top rsbs_top_asserts u_rsbs_asserts (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .events_i(events_i),
  .shared_port_pin_i(shared_port_pin_i), .lowvolt_enable_i(lowvolt_enable_i),
  .lowvolt_stop_enable_i(lowvolt_stop_enable_i), .in_stop_i(in_stop_i),
  .debug_mode_i(debug_mode_i), .clock_monitor_enable_i(clock_monitor_enable_i),
  .clock_mode_i(clock_mode_i), .shared_port_pin_o(shared_port_pin_o),
  .shared_port_pin_oe_o(shared_port_pin_oe_o), .domains_o(domains_o),
  .reset_source_status_reg_o(reset_source_status_reg_o), .lowvolt_active_o(lowvolt_active_o),
  .clock_monitor_active_o(clock_monitor_active_o), .core_fetch_start_o(core_fetch_start_o),
  .core_sp_addr_o(core_sp_addr_o), .core_pc_addr_o(core_pc_addr_o), .core_link_o(core_link_o)
);

// file: rsbs_top_test.sv
/*
  Self-checking bench for rsbs_top: power-on, each source except stop acknowledge, gating, pin, debug.
  Assumes the pin model on the far side and a 50 MHz clock.
*/
`timescale 1ns/1ps
module rsbs_top_test;
  // ----------------------------------------------------------------
  // Stimulus and wiring
  // ----------------------------------------------------------------
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  rsbs_pkg::rsbs_events_t ev = '0;
  rsbs_pkg::rsbs_events_t evt;
  rsbs_pkg::rsbs_filter_cfg_t cfg = '{use_lpo: 1'b0, width_m1: 12'h007};
  rsbs_pkg::rsbs_clkmode_t mode = rsbs_pkg::CLKMODE_EXT_ENGAGED;
  rsbs_pkg::rsbs_domains_t dom;
  logic rpe = 1'b1, lve = 1'b1, lvs = 1'b0, lvse = 1'b0, stp = 1'b0, dbgm = 1'b0;
  logic clock_monitor_enable = 1'b1, clr = 1'b0, hold_low = 1'b0, dsys = 1'b0, dhold = 1'b0;
  logic [7:0] rise = 8'h00;
  logic pin, pin_o, pin_oe, dsys_m, dhold_m, cg_en, cc_en, lv_act, lv_hi, cm_act, fetch;
  logic [rsbs_pkg::SRC_W-1:0] stat;
  logic [31:0] sp, pc, lr;
  int errors = 0, cmp_count = 0, cyc = 0;

  // Debug bits come from the far side model
  always_comb begin
    evt = ev;
    evt.dbg_sys_reset = dsys_m;
    evt.dbg_core_hold = dhold_m;
  end

  rsbs_top dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .events_i(evt), .reset_pin_enable_i(rpe),
    .shared_port_pin_i(pin), .pin_filter_cfg_i(cfg), .lowvolt_enable_i(lve),
    .lowvolt_level_select_i(lvs), .lowvolt_stop_enable_i(lvse), .in_stop_i(stp),
    .debug_mode_i(dbgm), .clock_monitor_enable_i(clock_monitor_enable), .clock_mode_i(mode),
    .status_clear_i(clr), .shared_port_pin_o(pin_o), .shared_port_pin_oe_o(pin_oe),
    .domains_o(dom), .reset_source_status_reg_o(stat), .clock_generator_enable_o(cg_en),
    .core_clock_enable_o(cc_en), .lowvolt_active_o(lv_act), .lowvolt_level_high_o(lv_hi),
    .clock_monitor_active_o(cm_act), .core_fetch_start_o(fetch), .core_sp_addr_o(sp),
    .core_pc_addr_o(pc), .core_link_o(lr));

  rsbs_pin_model u_far (.clock_i(clock_i), .drv_i(pin_o), .drv_oe_i(pin_oe),
    .hold_low_i(hold_low), .rise_cyc_i(rise), .dbg_sys_cmd_i(dsys), .dbg_hold_cmd_i(dhold),
    .pin_level_o(pin), .dbg_sys_o(dsys_m), .dbg_hold_o(dhold_m));

  initial begin
    forever #10 clock_i = ~clock_i;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic done(input string name);
    $display("test %s finished, mismatches so far %0d", name, errors);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Waits for the core start pulse; fl counts cycles from chip release
  task automatic boot(output int fl);
    int n;
    fl = 0;
    n = 0;
    while (fetch !== 1'b1 && n < 6000) begin
      if (dom.chip === 1'b0) fl++;
      step(1);
      n++;
    end
    chk(32'h1, fetch);
  endtask

  // Guards against a sequencer that never finishes
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_por();
    int n, fl;
    n = 0;
    while (pin_oe !== 1'b1 && n < 10) begin step(1); n++; end
    chk(9'h005, stat);
    n = 0;
    while (pin_oe === 1'b1 && n < 400) begin step(1); n++; end
    chk(32'h0000_00D2, n);
    chk(32'h1, cg_en);
    boot(fl);
    chk(32'h0000_0320, fl);
    chk(32'h0000_0000, sp);
    chk(32'h0000_0004, pc);
    chk(32'hFFFF_FFFF, lr);
    chk(32'h1, cc_en);
    chk(32'h0, {dom.por_only, dom.chip_por});
    done("power_on");
  endtask

  task automatic t_src(input int idx);
    int fl;
    case (idx)
      2: ev.lvd_trip = 1'b1;
      3: ev.watchdog_reset_flag_timeout = 1'b1;
      4: ev.loss_of_clock = 1'b1;
      6: ev.soft_reset_request = 1'b1;
      default: ev.lockup = 1'b1;
    endcase
    step(1);
    ev = '0;
    chk(32'h1 << idx, stat);
    chk(32'h3, {dom.chip, dom.early_chip});
    chk(idx == 2, dom.chip_por);
    chk(32'h0, dom.por_only);
    boot(fl);
    done("source");
  endtask

  task automatic t_refuse();
    int fl;
    mode = rsbs_pkg::CLKMODE_INT_BYPASS_LP;
    stp = 1'b1;
    lvs = 1'b1;
    step(3);
    chk(32'h0, cm_act);
    chk(32'h0, lv_act);
    chk(32'h1, lv_hi);
    ev.loss_of_clock = 1'b1;
    ev.lvd_trip = 1'b1;
    step(4);
    chk(32'h0, dom.chip);
    dbgm = 1'b1;
    step(4);
    ev = '0;
    chk(32'h1, dom.chip);
    chk(9'h004, stat);
    {stp, dbgm, lvs} = 3'h0;
    mode = rsbs_pkg::CLKMODE_EXT_ENGAGED;
    boot(fl);
    done("refuse");
  endtask

  task automatic t_pin();
    int fl;
    rpe = 1'b0;
    stp = 1'b1;
    hold_low = 1'b1;
    step(40);
    hold_low = 1'b0;
    step(12);
    chk(32'h0, dom.chip);
    rpe = 1'b1;
    hold_low = 1'b1;
    step(3);
    hold_low = 1'b0;
    step(12);
    chk(32'h0, dom.chip);
    rise = 8'h14;
    hold_low = 1'b1;
    step(300);
    chk(32'h1, dom.chip);
    chk(9'h002, stat);
    hold_low = 1'b0;
    stp = 1'b0;
    boot(fl);
    chk(32'h1, cc_en);
    rise = 8'h00;
    done("pin");
  endtask

  task automatic t_dbg();
    int n, fl;
    dsys = 1'b1;
    step(300);
    chk(32'h3, {dom.chip, dom.core});
    dsys = 1'b0;
    boot(fl);
    chk(9'h100, stat);
    dhold = 1'b1;
    ev.soft_reset_request = 1'b1;
    step(1);
    ev = '0;
    n = 0;
    while (dom.chip !== 1'b0 && n < 3000) begin step(1); n++; end
    step(900);
    chk(32'h2, {dom.core, fetch});
    chk(9'h040, stat);
    dhold = 1'b0;
    boot(fl);
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    chk(9'h000, stat);
    done("debug");
  endtask

  int src_tab[5] = '{3, 7, 6, 4, 2};

  initial begin
    step(20);
    rst_n_i = 1'b1;
    t_por();
    for (int i = 0; i < 5; i++) t_src(src_tab[i]);
    t_refuse();
    t_pin();
    t_dbg();
    report_and_stop();
  end
endmodule
